//--- include/async_frame_cfg.svh
// constants for the terminal-to-link frame buffer
// assumes a 20 MHz system clock and an external USART front end
`ifndef ASYNC_FRAME_CFG_SVH
`define ASYNC_FRAME_CFG_SVH
`define CLK_HZ 20000000
`define LINK_BPS 62500
`define LINK_DIV ((`CLK_HZ / `LINK_BPS))
`define FRAME_DATA_MAX 8'h3C
`define CTS_OFF_LEVEL 9'h0FC
`define CTS_ON_LEVEL 9'h0C0
`define RETRY_MAX 4'h4
`define RETRY_WAIT_US 1000
`define RETRY_WAIT_CYC ((`RETRY_WAIT_US * (`CLK_HZ / 1000000)))
`define CHAR_LF 8'h0A
`define CHAR_ESC 8'h1B
`define ADDR_CTRL 12'h000
`define ADDR_STATION 12'h004
`define ADDR_DEST 12'h008
`define ADDR_STATUS 12'h00C
`define ADDR_COUNT 12'h010
`define ADDR_ERROR 12'h014
`define CTRL_ONLINE 0
`define CTRL_ECHO 1
`define CTRL_TERM 2
`define ERR_PARITY 0
`define ERR_FRAMING 1
`define ERR_OVERRUN 2
`define ERR_OFFLINE 3
`endif

//--- include/async_frame_pkg.sv
// types for the terminal-to-link frame buffer
// assumes the cfg header supplies all numbers
package async_frame_pkg;
    typedef enum logic [1:0] {
        Q_EMPTY,
        Q_IN_USE,
        Q_FULL
    } queue_state_t;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic parity_err;
        logic framing_err;
        logic overrun_err;
    } uart_char_t;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic first;
        logic last;
    } frame_byte_t;
endpackage : async_frame_pkg

//--- verilog/async_to_frame_buffer.sv
// terminal side queue and packetizer toward the secondary link driver
// assumes USART flags and link driver signals are synchronous to clk_i
//
// Summary of operation
// - line feed requests sending buffered data as a frame
// - data beyond one frame splits into frames of sixty bytes max
// - line feed while offline reports unable-to-go-online error
// - discard characters with parity, framing or overrun error; report
// - two separate 256-byte queues, transmit and receive
// - queue full with zero pending frames bumps pending count
// - drop CTS just before queue full, restore after partial drain
// - escape character enters configure mode
// - in terminal mode, error-free non-escape characters go into the transmit queue unless it is full
// - echo accepted characters only when echo setting is on
// - pending count up per line feed in, down per line feed out
// - wait for link driver buffer free before loading a frame
// - destination address is first byte of each frame
// - loading stops at line feed, capacity, or empty queue
// - retry refused frames under a timer, then report error
// - eight-bit write and read indexes wrap naturally
// - after write, equal indexes mean full
// - after read, equal indexes mean empty
// - queue status is one of full, empty, in use
// - online opens link channel, offline closes it
// - start in terminal mode, send nothing until configured online
// - link set for clock recovery, NRZI, pre-frame sync, 62.5 Kbps
// - link driver clears buffer free on handover until acknowledged
//
// The address map and the APB interface to the registers were chosen for this implementation.
`include "async_frame_cfg.svh"
module async_to_frame_buffer #(
    parameter int RETRY_WAIT = `RETRY_WAIT_CYC,
    parameter int DEPTH_LOG2 = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire async_frame_pkg::apb_req_t apb_i,
    output async_frame_pkg::apb_rsp_t apb_o,
    input wire async_frame_pkg::uart_char_t rx_char_i,
    input wire logic echo_ready_i,
    output logic [7:0] echo_data_o,
    output logic echo_valid_o,
    output logic cts_o,
    input wire logic rx_link_valid_i,
    input wire logic [7:0] rx_link_data_i,
    output logic rx_link_ready_o,
    input wire logic term_ready_i,
    output logic [7:0] term_data_o,
    output logic term_valid_o,
    input wire logic buf_free_i,
    input wire logic send_ok_i,
    input wire logic send_fail_i,
    output async_frame_pkg::frame_byte_t frame_o,
    output logic send_req_o,
    output logic [7:0] send_len_o,
    output logic link_open_o,
    output logic link_close_o,
    output logic [7:0] station_addr_o,
    output logic [15:0] link_div_o,
    output logic link_nrzi_o,
    output logic link_clock_recovery_loop_o,
    output logic link_presync_o
);
    import async_frame_pkg::*;

    typedef enum {
        S_IDLE,
        S_WAIT_FREE,
        S_ADDR,
        S_DATA,
        S_SEND,
        S_WAIT_RES,
        S_RETRY
    } load_state_t;

    localparam int DEPTH = 1 << DEPTH_LOG2;

    // ----
    // state
    // ----
    // two queues
    logic [7:0] txq [DEPTH];
    logic [7:0] rxq [DEPTH];
    logic [DEPTH_LOG2-1:0] tx_write_index;
    logic [DEPTH_LOG2-1:0] tx_read_index;
    logic [DEPTH_LOG2-1:0] rx_wr_r;
    logic [DEPTH_LOG2-1:0] rx_rd_r;
    logic [DEPTH_LOG2:0] rx_cnt_r;
    queue_state_t tx_state_r;
    logic [8:0] tx_cnt_r;
    logic [8:0] pending_r;
    logic online_r;
    logic echo_en_r;
    logic term_mode_r;
    logic [7:0] dest_r;
    logic [3:0] err_r;
    load_state_t ld_r;
    logic [7:0] ld_cnt_r;
    logic [3:0] retry_r;
    logic [31:0] wait_r;

    logic rx_ok;
    logic tx_wr;
    logic tx_rd;
    logic [7:0] tx_head;
    logic is_lf_in;
    logic is_lf_out;
    logic auto_bump;
    logic bus_wr;
    logic err_set_any;

    assign tx_head = txq[tx_read_index];
    assign err_set_any = rx_char_i.valid &&
        (rx_char_i.parity_err || rx_char_i.framing_err ||
         rx_char_i.overrun_err);
    assign rx_ok = rx_char_i.valid && !err_set_any;
    assign tx_wr = rx_ok && term_mode_r && rx_char_i.data != `CHAR_ESC &&
        tx_state_r != Q_FULL;
    assign tx_rd = ld_r == S_DATA && tx_state_r != Q_EMPTY;
    assign is_lf_in = rx_char_i.data == `CHAR_LF;
    assign is_lf_out = tx_head == `CHAR_LF;
    assign auto_bump = tx_state_r == Q_FULL && pending_r == 9'h000;
    assign bus_wr = apb_i.psel && apb_i.penable && apb_i.pwrite;

    // ----
    // transmit queue
    // ----
    always_ff @(posedge clk_i) begin
        if (tx_wr) begin
            txq[tx_write_index] <= rx_char_i.data;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_write_index <= '0;
            tx_read_index <= '0;
            tx_cnt_r <= 9'h000;
        end else begin
            if (tx_wr) begin
                tx_write_index <= tx_write_index + 1'b1;
            end
            if (tx_rd) begin
                tx_read_index <= tx_read_index + 1'b1;
            end
            tx_cnt_r <= tx_cnt_r + {8'h00, tx_wr} - {8'h00, tx_rd};
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_state_r <= Q_EMPTY;
        end else if (tx_wr && !tx_rd) begin
            tx_state_r <= (tx_write_index + 1'b1 == tx_read_index) ?
                Q_FULL : Q_IN_USE;
        end else if (tx_rd && !tx_wr) begin
            tx_state_r <= (tx_read_index + 1'b1 == tx_write_index) ?
                Q_EMPTY : Q_IN_USE;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pending_r <= 9'h000;
        end else begin
            pending_r <= pending_r + {8'h00, tx_wr && is_lf_in || auto_bump}
                - {8'h00, tx_rd && is_lf_out && pending_r != 9'h000};
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cts_o <= 1'b1;
        end else if (tx_cnt_r >= `CTS_OFF_LEVEL) begin
            cts_o <= 1'b0;
        end else if (tx_cnt_r <= `CTS_ON_LEVEL) begin
            cts_o <= 1'b1;
        end
    end

    // ----
    // receive queue
    // ----
    always_ff @(posedge clk_i) begin
        if (rx_link_valid_i && rx_link_ready_o) begin
            rxq[rx_wr_r] <= rx_link_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_wr_r <= '0;
            rx_rd_r <= '0;
            rx_cnt_r <= '0;
            rx_link_ready_o <= 1'b0;
            term_valid_o <= 1'b0;
            term_data_o <= 8'h00;
        end else begin
            // stalls the link side rather than dropping bytes
            rx_link_ready_o <= rx_cnt_r < DEPTH_LOG2'(DEPTH - 2) + 9'h000;
            if (rx_link_valid_i && rx_link_ready_o) begin
                rx_wr_r <= rx_wr_r + 1'b1;
            end
            if (term_valid_o && term_ready_i) begin
                term_valid_o <= 1'b0;
            end else if (!term_valid_o && rx_cnt_r != '0) begin
                term_valid_o <= 1'b1;
                term_data_o <= rxq[rx_rd_r];
                rx_rd_r <= rx_rd_r + 1'b1;
            end
            rx_cnt_r <= rx_cnt_r + {8'h00, rx_link_valid_i && rx_link_ready_o}
                - {8'h00, !term_valid_o && rx_cnt_r != '0};
        end
    end

    // ----
    // echo and errors
    // ----
    // conditional echo
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            echo_valid_o <= 1'b0;
            echo_data_o <= 8'h00;
        end else if (tx_wr && echo_en_r) begin
            echo_valid_o <= 1'b1;
            echo_data_o <= rx_char_i.data;
        end else if (echo_ready_i) begin
            echo_valid_o <= 1'b0;
        end
    end

    // error flags: parity, framing, overrun, offline line feed or retries exhausted
    // sticky; set beats software clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            err_r <= 4'h0;
        end else begin
            err_r <= (bus_wr && apb_i.paddr == `ADDR_ERROR ?
                err_r & ~apb_i.pwdata[3:0] : err_r) |
                {(tx_wr && is_lf_in && !online_r) ||
                 (ld_r == S_RETRY && retry_r == `RETRY_MAX),
                 rx_char_i.valid && rx_char_i.overrun_err,
                 rx_char_i.valid && rx_char_i.framing_err,
                 rx_char_i.valid && rx_char_i.parity_err};
        end
    end

    // ----
    // frame loader
    // ----
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ld_r <= S_IDLE;
            ld_cnt_r <= 8'h00;
            retry_r <= 4'h0;
            wait_r <= 32'h0;
            frame_o <= '0;
            send_req_o <= 1'b0;
            send_len_o <= 8'h00;
        end else begin
            frame_o.valid <= 1'b0;
            send_req_o <= 1'b0;
            case (ld_r)
                S_IDLE: begin
                    // only when online
                    // auto sent data leaves no line feed behind
                    if (pending_r != 9'h000 && online_r &&
                        tx_state_r != Q_EMPTY) begin
                        ld_r <= S_WAIT_FREE;
                    end
                end
                S_WAIT_FREE: begin
                    if (buf_free_i) begin
                        ld_r <= S_ADDR;
                    end
                end
                S_ADDR: begin
                    frame_o <= '{valid: 1'b1, data: dest_r, first: 1'b1,
                        last: 1'b0};
                    ld_cnt_r <= 8'h00;
                    retry_r <= 4'h0;
                    ld_r <= S_DATA;
                end
                S_DATA: begin
                    if (tx_state_r == Q_EMPTY) begin
                        ld_r <= S_SEND;
                    end else begin
                        frame_o <= '{valid: 1'b1, data: tx_head, first: 1'b0,
                            last: is_lf_out ||
                                ld_cnt_r + 8'h01 == `FRAME_DATA_MAX};
                        ld_cnt_r <= ld_cnt_r + 8'h01;
                        if (is_lf_out || ld_cnt_r + 8'h01 == `FRAME_DATA_MAX
                            || tx_read_index + 1'b1 == tx_write_index) begin
                            ld_r <= S_SEND;
                        end
                    end
                end
                S_SEND: begin
                    send_req_o <= 1'b1;
                    send_len_o <= ld_cnt_r + 8'h01;
                    ld_r <= S_WAIT_RES;
                end
                S_WAIT_RES: begin
                    if (send_ok_i) begin
                        ld_r <= S_IDLE;
                    end else if (send_fail_i) begin
                        wait_r <= 32'h0;
                        retry_r <= retry_r + 4'h1;
                        ld_r <= S_RETRY;
                    end
                end
                S_RETRY: begin
                    if (retry_r == `RETRY_MAX) begin
                        ld_r <= S_IDLE;
                    end else if (wait_r == 32'(RETRY_WAIT - 1)) begin
                        ld_r <= S_SEND;
                    end else begin
                        wait_r <= wait_r + 32'h1;
                    end
                end
                default: begin
                    ld_r <= S_IDLE;
                end
            endcase
        end
    end

    // ----
    // config and APB
    // ----
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            online_r <= 1'b0;
            echo_en_r <= 1'b0;
            term_mode_r <= 1'b1;
            dest_r <= 8'h00;
            station_addr_o <= 8'h00;
            link_open_o <= 1'b0;
            link_close_o <= 1'b0;
        end else begin
            link_open_o <= 1'b0;
            link_close_o <= 1'b0;
            if (rx_ok && rx_char_i.data == `CHAR_ESC) begin
                term_mode_r <= 1'b0;
            end else if (bus_wr && apb_i.paddr == `ADDR_CTRL) begin
                term_mode_r <= apb_i.pwdata[`CTRL_TERM];
            end
            if (bus_wr && apb_i.paddr == `ADDR_CTRL) begin
                online_r <= apb_i.pwdata[`CTRL_ONLINE];
                echo_en_r <= apb_i.pwdata[`CTRL_ECHO];
                link_open_o <= apb_i.pwdata[`CTRL_ONLINE] && !online_r;
                link_close_o <= !apb_i.pwdata[`CTRL_ONLINE] && online_r;
            end
            if (bus_wr && apb_i.paddr == `ADDR_STATION) begin
                station_addr_o <= apb_i.pwdata[7:0];
            end
            if (bus_wr && apb_i.paddr == `ADDR_DEST) begin
                dest_r <= apb_i.pwdata[7:0];
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            link_div_o <= 16'h0000;
            link_nrzi_o <= 1'b0;
            link_clock_recovery_loop_o <= 1'b0;
            link_presync_o <= 1'b0;
        end else begin
            link_div_o <= 16'(`LINK_DIV);
            link_nrzi_o <= 1'b1;
            link_clock_recovery_loop_o <= 1'b1;
            link_presync_o <= 1'b1;
        end
    end

    // zero-wait slave; setup cycle decodes, access cycle answers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            apb_o <= '0;
        end else begin
            apb_o.pready <= apb_i.psel && !apb_i.penable;
            apb_o.pslverr <= 1'b0;
            apb_o.prdata <= 32'h0;
            if (apb_i.psel && !apb_i.penable) begin
                case (apb_i.paddr)
                    `ADDR_CTRL: apb_o.prdata <= {29'h0, term_mode_r,
                        echo_en_r, online_r};
                    `ADDR_STATION: apb_o.prdata <= {24'h0, station_addr_o};
                    `ADDR_DEST: apb_o.prdata <= {24'h0, dest_r};
                    `ADDR_STATUS: apb_o.prdata <= {29'h0, cts_o,
                        2'(tx_state_r)};
                    `ADDR_COUNT: apb_o.prdata <= {7'h0, pending_r, 7'h0,
                        tx_cnt_r};
                    `ADDR_ERROR: apb_o.prdata <= {28'h0, err_r};
                    default: apb_o.pslverr <= !apb_i.pwrite;
                endcase
            end
        end
    end
endmodule : async_to_frame_buffer

//--- tb/frame_buffer_properties.sv
// port checker for the terminal-to-link frame buffer
// assumes it is bound into async_to_frame_buffer
`include "async_frame_cfg.svh"
module frame_buffer_properties
    import async_frame_pkg::*;
#(
    parameter int RETRY_WAIT = 20,
    parameter int DEPTH_LOG2 = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire async_frame_pkg::apb_req_t apb_i,
    input wire async_frame_pkg::apb_rsp_t apb_o,
    input wire logic echo_ready_i,
    input wire logic [7:0] echo_data_o,
    input wire logic echo_valid_o,
    input wire logic buf_free_i,
    input wire async_frame_pkg::frame_byte_t frame_o,
    input wire logic send_req_o,
    input wire logic [7:0] send_len_o,
    input wire logic link_open_o,
    input wire logic link_close_o,
    input wire logic [15:0] link_div_o,
    input wire logic link_nrzi_o,
    input wire logic link_clock_recovery_loop_o,
    input wire logic link_presync_o
);
    logic wr_acc;
    logic online_r;
    logic echo_r;
    logic [7:0] dest_r;
    logic [7:0] cnt_r;
    assign wr_acc = apb_i.psel & apb_i.penable & apb_o.pready & apb_i.pwrite;
    // ----
    // written settings
    // ----
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            online_r <= 1'b0;
            echo_r <= 1'b0;
            dest_r <= 8'h00;
        end else if (wr_acc && apb_i.paddr == `ADDR_CTRL) begin
            online_r <= apb_i.pwdata[`CTRL_ONLINE];
            echo_r <= apb_i.pwdata[`CTRL_ECHO];
        end else if (wr_acc && apb_i.paddr == `ADDR_DEST) begin
            dest_r <= apb_i.pwdata[7:0];
        end
    end
    // bytes seen so far in the current frame, address included
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= 8'h00;
        end else if (frame_o.valid) begin
            cnt_r <= frame_o.first ? 8'h01 : cnt_r + 8'h01;
        end
    end
    // ----
    // properties
    // ----
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence ctrl_write_s;
        wr_acc && apb_i.paddr == `ADDR_CTRL;
    endsequence
    sequence go_online_s;
        ctrl_write_s ##0 (apb_i.pwdata[`CTRL_ONLINE] && !online_r);
    endsequence
    sequence go_offline_s;
        ctrl_write_s ##0 (!apb_i.pwdata[`CTRL_ONLINE] && online_r);
    endsequence
    AST_APB_ANSWER: assert property (apb_i.psel && !apb_i.penable |=>
        apb_o.pready) else $error("no ready");
    AST_READY_PULSE: assert property (apb_o.pready |=> !apb_o.pready)
        else $error("ready held");
    AST_OPEN_CHANNEL: assert property (go_online_s |-> ##[0:2] link_open_o)
        else $error("no open");
    AST_CLOSE_CHANNEL: assert property (go_offline_s |-> ##[0:2] link_close_o)
        else $error("no close");
    AST_SEND_ONLINE: assert property (send_req_o |-> online_r)
        else $error("sent offline");
    AST_DEST_FIRST: assert property (frame_o.valid && frame_o.first |->
        frame_o.data == dest_r) else $error("bad address");
    AST_LOAD_FREE: assert property (frame_o.valid && frame_o.first |->
        buf_free_i) else $error("buffer busy");
    AST_DATA_MAX: assert property (frame_o.valid && !frame_o.first |->
        cnt_r <= `FRAME_DATA_MAX) else $error("too long");
    AST_LEN_RANGE: assert property (send_req_o |-> send_len_o != 8'h00 &&
        send_len_o <= `FRAME_DATA_MAX + 8'h01) else $error("bad length");
    AST_SEND_PULSE: assert property (send_req_o |=> !send_req_o)
        else $error("send held");
    AST_ECHO_HOLD: assert property (echo_valid_o && !echo_ready_i |=>
        echo_valid_o && $stable(echo_data_o)) else $error("echo dropped");
    AST_ECHO_SETTING: assert property ($rose(echo_valid_o) |-> echo_r)
        else $error("echo off");
    AST_LINK_SETUP: assert property (!$past(rst_i) |->
        link_div_o == 16'(`LINK_DIV) && link_nrzi_o && link_clock_recovery_loop_o &&
        link_presync_o) else $error("link setup");
endmodule : frame_buffer_properties

bind async_to_frame_buffer frame_buffer_properties #(
    .RETRY_WAIT(RETRY_WAIT),
    .DEPTH_LOG2(DEPTH_LOG2)
) u_frame_buffer_properties (
    .clk_i, .rst_i, .apb_i, .apb_o, .echo_ready_i, .echo_data_o,
    .echo_valid_o, .buf_free_i, .frame_o, .send_req_o, .send_len_o,
    .link_open_o, .link_close_o, .link_div_o, .link_nrzi_o, .link_clock_recovery_loop_o,
    .link_presync_o
);

//--- tb/terminal_usart_model.sv
// stand-in for the async terminal behind its USART
// assumes send_char is called just after a rising edge
module terminal_usart_model import async_frame_pkg::*; (
    input wire logic clk_i,
    output async_frame_pkg::uart_char_t rx_char_o,
    output logic echo_ready_o,
    output logic term_ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        rx_char_o = '0;
        echo_ready_o = 1'b0;
        term_ready_o = 1'b1;
    end
    // echo taken every other cycle to exercise holding
    always @(posedge clk_i) begin
        echo_ready_o <= ~echo_ready_o;
    end
    // one-cycle strobe; idle data is the inverse of the last byte
    task automatic send_char(input logic [7:0] d, input logic [2:0] e);
        rx_char_o <= '{1'b1, d, e[0], e[1], e[2]};
        @(posedge clk_i);
        rx_char_o <= '{1'b0, ~d, 1'b0, 1'b0, 1'b0};
        repeat (2) @(posedge clk_i);
    endtask : send_char
endmodule : terminal_usart_model

//--- tb/async_to_frame_buffer_tb_top.sv
// self-checking bench for the terminal-to-link frame buffer
// assumes the terminal model and a simple link driver stand-in
`include "async_frame_cfg.svh"
module async_to_frame_buffer_tb_top import async_frame_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [11:0] a; logic [31:0] v;} row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    apb_req_t apb_i = '0;
    apb_rsp_t apb_o;
    uart_char_t rx_char_i;
    logic echo_ready_i, term_ready_i, echo_valid_o, cts_o, term_valid_o;
    logic buf_free_i = 1'b1, send_ok_i = 1'b0, send_fail_i = 1'b0;
    logic fail_mode = 1'b0;
    logic [4:0] busy = 5'h00;
    logic [7:0] echo_data_o, term_data_o, send_len_o, station_addr_o;
    logic send_req_o, link_open_o, link_close_o, rx_link_ready_o;
    logic link_nrzi_o, link_clock_recovery_loop_o, link_presync_o;
    logic [15:0] link_div_o;
    frame_byte_t frame_o;
    logic [7:0] fq[$], lens[$], dq[$];
    logic [31:0] q;
    logic e;
    int mismatches = 0, samples_checked = 0;
    int reqs = 0, opens = 0, closes = 0, echoes = 0;
    row_t rows[7] = '{'{`ADDR_CTRL, 32'h4}, '{`ADDR_STATION, 32'h0},
        '{`ADDR_DEST, 32'h0}, '{`ADDR_STATUS, 32'h4}, '{`ADDR_COUNT, 32'h0},
        '{`ADDR_ERROR, 32'h0}, '{12'h020, 32'h0}};
    always #25 clk_i = ~clk_i;
    async_to_frame_buffer #(.RETRY_WAIT(20), .DEPTH_LOG2(8))
    u_async_to_frame_buffer (
        .clk_i, .rst_i, .apb_i, .apb_o, .rx_char_i, .echo_ready_i,
        .echo_data_o, .echo_valid_o, .cts_o, .rx_link_valid_i(1'b0),
        .rx_link_data_i(8'h00), .rx_link_ready_o, .term_ready_i,
        .term_data_o, .term_valid_o, .buf_free_i, .send_ok_i, .send_fail_i,
        .frame_o, .send_req_o, .send_len_o, .link_open_o, .link_close_o,
        .station_addr_o, .link_div_o, .link_nrzi_o, .link_clock_recovery_loop_o,
        .link_presync_o);
    terminal_usart_model u_term (.clk_i, .rx_char_o(rx_char_i),
        .echo_ready_o(echo_ready_i), .term_ready_o(term_ready_i));
    // ----
    // link driver stand-in, monitors
    // ----
    // free dropped until answer
    always @(posedge clk_i) begin
        busy <= (send_req_o === 1'b1) ? 5'h06 : busy - 5'(busy != 5'h00);
        buf_free_i <= (send_req_o === 1'b1) ? 1'b0 : buf_free_i | busy == 5'h01;
        send_ok_i <= busy == 5'h01 && !fail_mode;
        send_fail_i <= busy == 5'h01 && fail_mode;
        if (frame_o.valid === 1'b1) fq.push_back(frame_o.data);
        if (send_req_o === 1'b1) lens.push_back(send_len_o);
        reqs += int'(send_req_o === 1'b1);
        opens += int'(link_open_o === 1'b1);
        closes += int'(link_close_o === 1'b1);
        echoes += int'(echo_valid_o === 1'b1 && echo_ready_i === 1'b1);
    end
    // ----
    // tasks
    // ----
    task automatic cmp(input string what, input logic [31:0] ex,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== ex) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, ex, got);
        end
    endtask : cmp
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        apb_i <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_i);
        apb_i.penable <= 1'b1;
        do @(posedge clk_i); while (apb_o.pready !== 1'b1);
        q = apb_o.prdata;
        e = apb_o.pslverr;
        apb_i.psel <= 1'b0;
        apb_i.penable <= 1'b0;
        @(posedge clk_i);
    endtask : xfer
    task automatic rd_chk(input string what, input logic [11:0] a,
                          input logic [31:0] ex);
        xfer(1'b0, a, 32'h0);
        cmp(what, ex, q);
    endtask : rd_chk
    task automatic chk_frame(input logic [7:0] ex[$]);
        while (lens.size() == 0) @(posedge clk_i);
        cmp("frame length", 32'(ex.size()), 32'(lens.pop_front()));
        foreach (ex[i]) cmp("frame byte", 32'(ex[i]), 32'(fq.pop_front()));
    endtask : chk_frame
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    // ----
    // main sequence
    // ----
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (rows[i]) rd_chk("register", rows[i].a, rows[i].v);
        cmp("unmapped error", 32'h1, 32'(e));
        cmp("cts after reset", 32'h1, 32'(cts_o));
        cmp("link divider", 32'(`LINK_DIV), 32'(link_div_o));
        cmp("link coding", 32'h7, 32'({link_nrzi_o, link_clock_recovery_loop_o, link_presync_o}));
        for (int k = 0; k < 3; k++) begin
            u_term.send_char(8'h41, 3'(1 << k));
            rd_chk("error flags", `ADDR_ERROR, 32'(1 << k));
            xfer(1'b1, `ADDR_ERROR, 32'(1 << k));
        end
        rd_chk("bad chars dropped", `ADDR_COUNT, 32'h0);
        u_term.send_char(8'h41, 3'h0);
        u_term.send_char(8'h42, 3'h0);
        u_term.send_char(`CHAR_LF, 3'h0);
        rd_chk("offline notice", `ADDR_ERROR, 32'h8);
        rd_chk("queued bytes", `ADDR_COUNT, 32'h0001_0003);
        cmp("no frame offline", 32'h0, 32'(reqs));
        xfer(1'b1, `ADDR_ERROR, 32'hF);
        xfer(1'b1, `ADDR_DEST, 32'h5A);
        xfer(1'b1, `ADDR_STATION, 32'h33);
        cmp("station address", 32'h33, 32'(station_addr_o));
        xfer(1'b1, `ADDR_CTRL, 32'h5);
        chk_frame('{8'h5A, 8'h41, 8'h42, 8'h0A});
        cmp("link opened", 32'h1, 32'(opens));
        rd_chk("drained", `ADDR_COUNT, 32'h0);
        rd_chk("status empty", `ADDR_STATUS, 32'h4);
        xfer(1'b1, `ADDR_CTRL, 32'h7);
        for (int i = 0; i < 70; i++) begin
            dq.push_back(8'h61 + 8'(i % 26));
            u_term.send_char(dq[i], 3'h0);
        end
        u_term.send_char(`CHAR_LF, 3'h0);
        chk_frame({8'h5A, dq[0:59]});
        chk_frame({8'h5A, dq[60:69], 8'h0A});
        cmp("echo count", 32'd71, 32'(echoes));
        u_term.send_char(`CHAR_ESC, 3'h0);
        rd_chk("configure mode", `ADDR_CTRL, 32'h3);
        xfer(1'b1, `ADDR_CTRL, 32'h4);
        dq.delete();
        for (int i = 0; i < 256; i++) begin
            dq.push_back(8'h20 + 8'(i % 64));
            u_term.send_char(dq[i], 3'h0);
            if (i == 250) cmp("cts below limit", 32'h1, 32'(cts_o));
            if (i == 251) cmp("cts at limit", 32'h0, 32'(cts_o));
        end
        rd_chk("status full", `ADDR_STATUS, 32'h2);
        cmp("link closed", 32'h1, 32'(closes));
        rd_chk("auto send", `ADDR_COUNT, 32'h0001_0100);
        u_term.send_char(8'h7E, 3'h0);
        rd_chk("no overwrite", `ADDR_COUNT, 32'h0001_0100);
        xfer(1'b1, `ADDR_CTRL, 32'h5);
        for (int f = 0; f < 5; f++) begin
            chk_frame({8'h5A, dq[f * 60 : (f < 4 ? f * 60 + 59 : 255)]});
        end
        xfer(1'b0, `ADDR_STATUS, 32'h0);
        cmp("empty after drain", 32'h0, 32'(q[1:0]));
        cmp("cts restored", 32'h1, 32'(cts_o));
        xfer(1'b1, `ADDR_ERROR, 32'hF);
        fail_mode <= 1'b1;
        reqs = 0;
        u_term.send_char(8'h58, 3'h0);
        u_term.send_char(`CHAR_LF, 3'h0);
        for (int n = 0; n < 200 && q[3] !== 1'b1; n++) xfer(1'b0, `ADDR_ERROR, 32'h0);
        cmp("retries give up", 32'h8, q & 32'h8);
        cmp("attempts", 32'(`RETRY_MAX), 32'(reqs));
        wrap_up();
    end
    initial begin
        repeat (30000) @(posedge clk_i);
        mismatches++;
        wrap_up();
    end
endmodule : async_to_frame_buffer_tb_top
